// ===== logic/rx_mode_ctrl_pkg.sv
// constants and carrier types for the receive mode command control word
package rx_mode_ctrl_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int WORD_WIDTH = 16;
  localparam int BIT_INDEX_ZERO_IRQ = 15;
  localparam int BIT_IRQ_WHEN_ACCESSED = 14;
  localparam int BIT_IRQ_BROADCAST = 13;
  localparam int BIT_FORCE_BUSY = 12;
  localparam int BIT_ACCESSED = 11;
  localparam int BIT_POINTER = 10;
  localparam int BIT_STOP_PING_PONG = 3;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [4:0] BROADCAST_ADDRESS = 5'h1F;
  localparam logic [4:0] MODE_SUBADDR_LOW = 5'h00;
  localparam logic [4:0] MODE_SUBADDR_HIGH = 5'h1F;
  localparam logic [4:0] FIRST_DATA_MODE = 5'h10;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_when_accessed_en;
    logic irq_broadcast_en;
    logic broadcast_invalidate;
    logic global_busy;
    logic pointer_toggle_off;
    logic terminal_executing;
    logic ping_pong_mode;
  } config_type;

  typedef struct packed {
    logic [4:0] rt_address;
    logic tr;
    logic [4:0] subaddress;
    logic [4:0] mode_code;
  } command_type;

  typedef struct packed {
    logic error;
    logic illegal;
  } completion_type;

  typedef struct packed {
    logic when_accessed;
    logic broadcast_received;
  } irq_type;

endpackage : rx_mode_ctrl_pkg

// ===== logic/mode_cmd_match.sv
// decoder that tells whether a command word addresses this mode code
`timescale 1ns/100ps
module mode_cmd_match
  import rx_mode_ctrl_pkg::*;
#(
  parameter logic [4:0] MODE_CODE = 5'h00
) (
  input wire command_type cmd,
  input wire logic broadcast_invalidate,
  output logic match,
  output logic broadcast
);

  logic is_bcast;

  always_comb begin
    is_bcast = (cmd.rt_address == BROADCAST_ADDRESS);
    // receive only, subaddress 0 or 31
    // invalidated broadcasts are not valid commands
    match = !cmd.tr &&
            (cmd.subaddress == MODE_SUBADDR_LOW ||
             cmd.subaddress == MODE_SUBADDR_HIGH) &&
            cmd.mode_code == MODE_CODE &&
            !(is_bcast && broadcast_invalidate);
    broadcast = match && is_bcast;
  end

endmodule : mode_cmd_match

// ===== logic/rx_mode_ctrl.sv
// receive mode command control word with its command-side behaviour
`timescale 1ns/100ps
module rx_mode_ctrl
  import rx_mode_ctrl_pkg::*;
#(
  parameter logic [4:0] MODE_CODE = 5'h00
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SOFTWARE_RESET,
  input wire config_type CFG,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [15:0] HOST_WDATA,
  output logic [15:0] HOST_RDATA,
  input wire logic CMD_START,
  input wire command_type CMD_WORD,
  input wire logic DATA_STROBE,
  input wire logic CMD_DONE,
  input wire completion_type CMD_STATUS,
  output logic BUSY_REPLY,
  output logic DATA_STORE,
  output logic BUFFER_B_SELECT,
  output irq_type IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {IDLE, ACTIVE} phase_type;

  typedef struct packed {
    phase_type phase;
    logic index_zero_irq;
    logic irq_when_accessed;
    logic irq_broadcast;
    logic force_busy;
    logic accessed;
    logic pointer;
    logic stop_ping_pong;
    logic busy;
    logic bcast;
    logic buffer_b;
    logic data_store;
    irq_type irq;
    logic [15:0] rdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    phase: IDLE,
    irq: '0,
    rdata: WORD_RESET,
    default: 1'b0
  };

  // one flop per field position; other widths break word_of
  if (WORD_WIDTH != 16) begin : g_bad_width
    $error("control word must be 16 bits wide");
  end

  state_type st;
  state_type next_st;
  logic match;
  logic bcast;
  logic done_now;
  logic toggle_now;

  mode_cmd_match #(
    .MODE_CODE(MODE_CODE)
  ) u_match (
    .cmd(CMD_WORD),
    .broadcast_invalidate(CFG.broadcast_invalidate),
    .match(match),
    .broadcast(bcast)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] word_of(input state_type s);
    logic [15:0] w;
    w = WORD_RESET;
    w[BIT_INDEX_ZERO_IRQ] = s.index_zero_irq;
    w[BIT_IRQ_WHEN_ACCESSED] = s.irq_when_accessed;
    w[BIT_IRQ_BROADCAST] = s.irq_broadcast;
    w[BIT_FORCE_BUSY] = s.force_busy;
    w[BIT_ACCESSED] = s.accessed;
    w[BIT_POINTER] = s.pointer;
    w[BIT_STOP_PING_PONG] = s.stop_ping_pong;
    return w;
  endfunction : word_of

  function automatic logic carries_data(input logic [4:0] mc);
    return mc >= FIRST_DATA_MODE;
  endfunction : carries_data

  assign done_now = (st.phase == ACTIVE) && CMD_DONE;
  // busy messages keep the pointer; illegal ones too when toggle is off
  assign toggle_now = done_now && CFG.ping_pong_mode &&
                      !CMD_STATUS.error && !st.busy &&
                      !(CMD_STATUS.illegal && CFG.pointer_toggle_off);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.irq = '0;
    next_st.data_store = 1'b0;

    // bits 3 and 12..15 open at any time; 8..11 never
    if (HOST_WR) begin
      next_st.index_zero_irq = HOST_WDATA[BIT_INDEX_ZERO_IRQ];
      next_st.irq_when_accessed = HOST_WDATA[BIT_IRQ_WHEN_ACCESSED];
      next_st.irq_broadcast = HOST_WDATA[BIT_IRQ_BROADCAST];
      next_st.force_busy = HOST_WDATA[BIT_FORCE_BUSY];
      next_st.stop_ping_pong = HOST_WDATA[BIT_STOP_PING_PONG];
    end

    // read returns the word before the clear takes effect
    if (HOST_RD) begin
      next_st.rdata = word_of(st);
      next_st.accessed = 1'b0;
    end

    unique case (st.phase)
      IDLE: begin
        // commands are only accepted while the terminal executes
        if (CMD_START && match && CFG.terminal_executing) begin
          next_st.phase = ACTIVE;
          // per-code or global busy
          next_st.busy = st.force_busy || CFG.global_busy;
          next_st.bcast = bcast;
          // indexed mode ignores the pointer
          next_st.buffer_b = CFG.ping_pong_mode && st.pointer;
        end
      end
      ACTIVE: begin
        if (DATA_STROBE && !st.busy && carries_data(MODE_CODE)) begin
          next_st.data_store = 1'b1;
        end
        if (CMD_DONE) begin
          next_st.phase = IDLE;
          next_st.busy = 1'b0;
          next_st.bcast = 1'b0;
          next_st.accessed = 1'b1;
          next_st.irq.when_accessed = st.irq_when_accessed &&
                                      CFG.irq_when_accessed_en;
          next_st.irq.broadcast_received = st.bcast && st.irq_broadcast &&
                                           CFG.irq_broadcast_en;
          if (toggle_now) begin
            next_st.pointer = !st.pointer;
          end
        end
      end
    endcase

    // software reset dominates every event of the same cycle for accessed, pointer and bcast
    if (SOFTWARE_RESET) begin
      next_st.accessed = 1'b0;
      next_st.pointer = 1'b0;
      next_st.bcast = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HOST_RDATA = st.rdata;
  assign BUSY_REPLY = st.busy;
  assign DATA_STORE = st.data_store;
  assign BUFFER_B_SELECT = st.buffer_b;
  // one-cycle requests to pending register, pin and log
  assign IRQ = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_accessed_irq: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    done_now && st.irq_when_accessed && CFG.irq_when_accessed_en
    |=> IRQ.when_accessed)
    else $error("missing interrupt request for valid mode command");

  a_irq_at_end: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    IRQ.when_accessed || IRQ.broadcast_received
    |-> $past(done_now) && st.phase == IDLE)
    else $error("interrupt request outside command completion");

  a_bcast_request: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    IRQ.broadcast_received |-> $past(st.bcast) && $past(st.irq_broadcast))
    else $error("broadcast request without a broadcast command");

  a_bcast_invalid: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CMD_START && CFG.broadcast_invalidate &&
    CMD_WORD.rt_address == BROADCAST_ADDRESS && st.phase == IDLE
    |=> st.phase == IDLE)
    else $error("invalidated broadcast was accepted");

  a_busy_reply: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE && CMD_START && match && CFG.terminal_executing &&
    (st.force_busy || CFG.global_busy)
    |=> BUSY_REPLY throughout (st.phase == ACTIVE))
    else $error("busy command answered without busy");

  a_busy_no_store: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    BUSY_REPLY |=> !DATA_STORE)
    else $error("data stored while busy");

  a_done_sets_flag: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    done_now && !SOFTWARE_RESET |=> st.accessed)
    else $error("accessed flag not set at completion");

  a_read_clears_flag: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    HOST_RD && !done_now |=> !st.accessed ##0 HOST_RDATA[BIT_ACCESSED] ==
    $past(st.accessed))
    else $error("read did not clear accessed flag");

  a_pointer_toggle: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    toggle_now && !SOFTWARE_RESET |=> st.pointer != $past(st.pointer))
    else $error("pointer did not toggle after good message");

  a_pointer_kept: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    !toggle_now && !SOFTWARE_RESET |=> $stable(st.pointer))
    else $error("pointer changed without a good message");

  a_swreset_clear: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    SOFTWARE_RESET |=> !st.pointer && !st.accessed)
    else $error("software reset left pointer or flag set");

  a_indexed_buffer_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE && CMD_START && match && CFG.terminal_executing &&
    !CFG.ping_pong_mode |=> !BUFFER_B_SELECT)
    else $error("indexed mode used the pointer");

  a_host_write: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    HOST_WR |=> st.force_busy == $past(HOST_WDATA[BIT_FORCE_BUSY]) &&
    st.stop_ping_pong == $past(HOST_WDATA[BIT_STOP_PING_PONG]))
    else $error("host write to open bits was lost");

  // accepted-start condition spelled out in full at each check
  a_global_busy: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE && CMD_START && match && CFG.terminal_executing &&
    CFG.global_busy |=> BUSY_REPLY)
    else $error("global busy not applied to accepted command");

  a_busy_released: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    done_now |=> !BUSY_REPLY && st.phase == IDLE)
    else $error("busy held past command completion");

  a_data_stored: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == ACTIVE && DATA_STROBE && !st.busy &&
    MODE_CODE >= FIRST_DATA_MODE |=> DATA_STORE)
    else $error("data word of a ready command not stored");

  a_idle_no_store: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE |=> !DATA_STORE)
    else $error("data stored outside a command");

  a_pointer_select: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE && CMD_START && match && CFG.terminal_executing &&
    CFG.ping_pong_mode
    |=> BUFFER_B_SELECT == $past(st.pointer))
    else $error("buffer select does not follow the pointer");

  a_receive_only: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    st.phase == IDLE && CMD_START && (CMD_WORD.tr ||
    (CMD_WORD.subaddress != MODE_SUBADDR_LOW &&
     CMD_WORD.subaddress != MODE_SUBADDR_HIGH)) |=> st.phase == IDLE)
    else $error("command outside the receive layout accepted");

  // read, completion and software reset may move the flag legally
  a_write_blocked: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    HOST_WR && !HOST_RD && !done_now && !SOFTWARE_RESET
    |=> st.accessed == $past(st.accessed))
    else $error("host write reached the accessed flag");

endmodule : rx_mode_ctrl

// ===== verification/mode_cmd_source.sv
// bus controller model issuing one mode command message at a time
`timescale 1ns/100ps
module mode_cmd_source
  import rx_mode_ctrl_pkg::*;
(
  input wire logic CLK,
  output logic CMD_START,
  output command_type CMD_WORD,
  output logic DATA_STROBE,
  output logic CMD_DONE,
  output completion_type CMD_STATUS,
  input wire logic BUSY_REPLY,
  input wire logic DATA_STORE,
  input wire logic BUFFER_B_SELECT,
  input wire irq_type IRQ
);
  initial begin
    CMD_START = 1'b0;
    CMD_WORD = 16'hFFFF;
    DATA_STROBE = 1'b0;
    CMD_DONE = 1'b0;
    CMD_STATUS = 2'h3;
  end

  // start, one data word, done; reply sampled once each edge has landed
  task automatic send(input command_type cmd, input completion_type st,
                      output logic [4:0] seen);
    @(posedge CLK) #1;
    CMD_START = 1'b1;
    CMD_WORD = cmd;
    @(posedge CLK) #1;
    CMD_START = 1'b0;
    // word is not held past its start, so stale values never pass
    CMD_WORD = ~cmd;
    DATA_STROBE = 1'b1;
    seen[4] = BUSY_REPLY;
    seen[2] = BUFFER_B_SELECT;
    @(posedge CLK) #1;
    DATA_STROBE = 1'b0;
    seen[3] = DATA_STORE;
    CMD_DONE = 1'b1;
    CMD_STATUS = st;
    @(posedge CLK) #1;
    CMD_DONE = 1'b0;
    CMD_STATUS = ~st;
    seen[1:0] = IRQ;
    @(posedge CLK) #1;
  endtask : send
endmodule : mode_cmd_source

// ===== verification/test_rx_mode_ctrl.sv
// directed testbench for the receive mode command control word
`timescale 1ns/100ps
module test_rx_mode_ctrl;
  import rx_mode_ctrl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic software_reset = 1'b0;
  config_type cfg = 7'b1100011;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  logic cmd_start, data_strobe, cmd_done, busy_reply, data_store, buf_b;
  command_type cmd_word;
  completion_type cmd_status;
  irq_type irq;
  int err_count = 0;
  int check_count = 0;
  localparam command_type UNI = {5'h05, 1'b0, 5'h00, 5'h11};
  localparam command_type BCST = {5'h1F, 1'b0, 5'h1F, 5'h11};

  always #5 clk = ~clk;

  rx_mode_ctrl #(.MODE_CODE(5'h11)) i_dut (.CLK(clk), .SYS_RST(sys_rst),
    .SOFTWARE_RESET(software_reset), .CFG(cfg), .HOST_WR(host_wr),
    .HOST_RD(host_rd), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .CMD_START(cmd_start), .CMD_WORD(cmd_word), .DATA_STROBE(data_strobe),
    .CMD_DONE(cmd_done), .CMD_STATUS(cmd_status), .BUSY_REPLY(busy_reply),
    .DATA_STORE(data_store), .BUFFER_B_SELECT(buf_b), .IRQ(irq));

  mode_cmd_source i_bc (.CLK(clk), .CMD_START(cmd_start),
    .CMD_WORD(cmd_word), .DATA_STROBE(data_strobe), .CMD_DONE(cmd_done),
    .CMD_STATUS(cmd_status), .BUSY_REPLY(busy_reply),
    .DATA_STORE(data_store), .BUFFER_B_SELECT(buf_b), .IRQ(irq));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] d);
    @(posedge clk) #1;
    host_wr = 1'b1;
    host_wdata = d;
    @(posedge clk) #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] exp);
    @(posedge clk) #1;
    host_rd = 1'b1;
    @(posedge clk) #1;
    host_rd = 1'b0;
    chk("word", exp, host_rdata);
  endtask : rd

  // reply packed as busy, store, buffer b, irq accessed, irq broadcast
  task automatic msg(input command_type c, input completion_type st,
                     input logic [4:0] exp);
    logic [4:0] seen;
    i_bc.send(c, st, seen);
    chk("reply", {11'h000, exp}, {11'h000, seen});
  endtask : msg

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(16'h0000);
    wr(16'hFFFF);
    rd(16'hF008);
    cfg.terminal_executing = 1'b0;
    wr(16'h6008);
    // no terminal execution, so the command is not taken
    msg(UNI, 2'b00, 5'b00000);
    rd(16'h6008);
    cfg.terminal_executing = 1'b1;
    $display("test host access done");
    msg(UNI, 2'b00, 5'b01010);
    rd(16'h6C08);
    rd(16'h6408);
    msg(BCST, 2'b00, 5'b01111);
    rd(16'h6808);
    cfg.broadcast_invalidate = 1'b1;
    // refused commands leave the buffer select of the last message
    msg(BCST, 2'b00, 5'b00100);
    rd(16'h6008);
    cfg.broadcast_invalidate = 1'b0;
    msg({5'h05, 1'b1, 5'h00, 5'h11}, 2'b00, 5'b00100);
    msg({5'h05, 1'b0, 5'h01, 5'h11}, 2'b00, 5'b00100);
    $display("test interrupts done");
    wr(16'h7008);
    msg(UNI, 2'b00, 5'b10010);
    rd(16'h7808);
    wr(16'h6008);
    cfg.global_busy = 1'b1;
    msg(UNI, 2'b00, 5'b10010);
    rd(16'h6808);
    cfg.global_busy = 1'b0;
    $display("test busy done");
    msg(UNI, 2'b10, 5'b01010);
    rd(16'h6808);
    // illegal still toggles while toggle off is clear
    msg(UNI, 2'b01, 5'b01010);
    rd(16'h6C08);
    // toggle off set as software should, so illegal keeps the pointer
    cfg.pointer_toggle_off = 1'b1;
    msg(UNI, 2'b01, 5'b01110);
    rd(16'h6C08);
    // pointer now at B, yet indexed mode stays on buffer A
    cfg.ping_pong_mode = 1'b0;
    msg(UNI, 2'b00, 5'b01010);
    cfg.ping_pong_mode = 1'b1;
    @(posedge clk) #1 software_reset = 1'b1;
    @(posedge clk) #1 software_reset = 1'b0;
    rd(16'h6008);
    msg(UNI, 2'b00, 5'b01010);
    $display("test pointer done");
    end_sim();
  end
endmodule : test_rx_mode_ctrl
